// *** common/two_wire_consts.svh ***
// Register offsets, field positions, status codes and reset values.
`ifndef TWO_WIRE_CONSTS_SVH
`define TWO_WIRE_CONSTS_SVH
// Register indices on the local register port.
`define OFS_OWN_ADDR      2'h0
`define OFS_CONTROL       2'h1
`define OFS_STATUS        2'h2
`define OFS_DATA          2'h3
// Control register bit positions.
`define CTL_STEP_DONE     7
`define CTL_ACK_EN        6
`define CTL_START_REQ     5
`define CTL_STOP_REQ      4
`define CTL_WCOL          3
`define CTL_IFACE_EN      2
`define CTL_IRQ_EN        0
// Own-address register: general call enable bit.
`define OWN_GC_EN         0
// Status codes, prescaler bits masked to zero.
`define ST_OWN_W_ACK      8'h60
`define ST_ARB_OWN_W      8'h68
`define ST_GC_ACK         8'h70
`define ST_ARB_GC         8'h78
`define ST_DATA_ACK       8'h80
`define ST_DATA_NACK      8'h88
`define ST_GC_DATA_ACK    8'h90
`define ST_GC_DATA_NACK   8'h98
`define ST_STOP_RESTART   8'ha0
`define ST_OWN_R_ACK      8'ha8
`define ST_ARB_OWN_R      8'hb0
`define ST_TX_ACK         8'hb8
`define ST_TX_NACK        8'hc0
`define ST_TX_LAST_ACK    8'hc8
`define ST_NO_INFO        8'hf8
`define ST_BUS_ERROR      8'h00
`define ST_CODE_MASK      8'hf8
// General call address, reset values and bit counts.
`define GENERAL_CALL_ADDR 7'h00
`define RST_OWN_ADDR      8'h00
`define RST_BYTE          8'h00
`define BITS_PER_BYTE     4'h8
`define LAST_TX_BIT       4'h7
`endif

// *** common/two_wire_pkg.sv ***
// Types shared by the two-wire slave engine and its pin synchroniser.
package two_wire_pkg;
   // Phases of the slave engine.
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_ADDR = 3'b001,
      PH_ACK  = 3'b010,
      PH_HOLD = 3'b011,
      PH_RX   = 3'b100,
      PH_TX   = 3'b101,
      PH_MACK = 3'b110
   } phase_t;
   // One access on the local register port.
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } host_req_t;
   // State of one pin synchroniser.
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } sync_state_t;
endpackage : two_wire_pkg

// *** rtl/pin_sync.sv ***
// Three-stage synchroniser with a settled level for one bus pin.
`timescale 1ns/100ps
module pin_sync #(
   parameter logic RST_LEVEL = 1'b1
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic pin,
   output logic      level
);
   two_wire_pkg::sync_state_t q;
   two_wire_pkg::sync_state_t d;

   // The level follows only once stages two and three agree.
   always_comb begin
      d = q;
      d.s1 = pin;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3) begin
         d.lvl = q.s3;
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= {4{RST_LEVEL}};
      end else begin
         q <= d;
      end
   end

   assign level = q.lvl;
endmodule : pin_sync

// *** rtl/two_wire_slave_engine.sv ***
// Slave engine of a two-wire serial interface with local registers.
`timescale 1ns/100ps
`include "two_wire_consts.svh"

// Summary of operation
// R1 - Acked general-call data reports 0x90.
// R2 - Nacked general-call data: 0x98, then unaddressed.
// R3 - STOP or restart while addressed reports 0xA0.
// R4 - Ack enable and general-call enable gate recognition.
// R5 - Pending start request issues START when bus frees.
// R6 - Upper seven own-address bits give slave address.
// R7 - Own-address bit zero enables general call.
// R8 - Software sets enable and ack, clears start/stop.
// R9 - Read bit selects transmit, else receive.
// R10 - Address match sets step flag and status.
// R11 - Lost arbitration then read reports 0xB0.
// R12 - Ack enable clear sends last byte; 0xC0/0xC8.
// R13 - After last byte ignore master, line stays high.
// R14 - Ack enable zero ignores address, keeps monitoring.
// R15 - In deep sleep, address match wakes the part.
// R16 - Clock line held low until flag cleared, after an address, 0x80/0x90 or 0xB8.
// R17 - Data register need not hold byte after wake.
// R18 - Software masks prescaler bits before comparing.
// R19 - Transmit states load byte; ack enable picks last.
// R20 - Misplaced START/STOP gives 0x00; stop request recovers.
module two_wire_slave_engine (
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   input  wire two_wire_pkg::host_req_t busReq,
   output logic [7:0]                   rdData,
   input  wire logic                    sclIn,
   output logic                         sclOut,
   output logic                         sclOe,
   input  wire logic                    sdaIn,
   output logic                         sdaOut,
   output logic                         sdaOe,
   input  wire logic                    arbLost,
   input  wire logic                    sleepDeep,
   output logic                         wakeUp,
   output logic                         startIssue,
   output logic                         stepDone
);
   // Whole engine state.
   typedef struct packed {
      two_wire_pkg::phase_t st;
      two_wire_pkg::phase_t nextSt;
      logic [3:0]           cnt;
      logic [7:0]           sh;
      logic [7:0]           txSh;
      logic [7:0]           dataReg;
      logic [7:0]           ownAddr;
      logic [7:0]           code;
      logic [1:0]           presc;
      logic                 flag;
      logic                 ackEn;
      logic                 startReq;
      logic                 stopReq;
      logic                 wcol;
      logic                 ifaceEn;
      logic                 irqEn;
      logic                 stretch;
      logic                 sclHold;
      logic                 sdaDrv;
      logic                 addrPhase;
      logic                 rdMode;
      logic                 gc;
      logic                 ackNext;
      logic                 lastByte;
      logic                 mAck;
      logic                 arb;
      logic                 startPend;
      logic                 busy;
      logic                 sclPrev;
      logic                 sdaPrev;
      logic                 wake;
      logic                 startOut;
      logic [7:0]           rdata;
   } engine_state_t;

   engine_state_t q;
   engine_state_t d;
   logic          sclS;
   logic          sdaS;
   logic          sclRise;
   logic          sclFall;
   logic          startCond;
   logic          stopCond;
   logic          ownHit;
   logic          gcHit;
   logic          clearFlag;

   // Both bus lines enter through three-stage synchronisers.
   pin_sync #(.RST_LEVEL(1'b1)) u_scl_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .pin   (sclIn),
      .level (sclS)
   );
   pin_sync #(.RST_LEVEL(1'b1)) u_sda_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .pin   (sdaIn),
      .level (sdaS)
   );

   // Edge and condition detection on the settled line levels.
   assign sclRise   = sclS & ~q.sclPrev;
   assign sclFall   = ~sclS & q.sclPrev;
   assign startCond = sclS & q.sclPrev & ~sdaS & q.sdaPrev;
   assign stopCond  = sclS & q.sclPrev & sdaS & ~q.sdaPrev;

   // Address recognition, gated by ack enable at match time.
   assign ownHit = q.ackEn & q.ifaceEn &                  // [R4] [R14]
                   (q.sh[7:1] == q.ownAddr[7:1]);         // [R6]
   assign gcHit  = q.ackEn & q.ifaceEn &                  // [R4]
                   q.ownAddr[`OWN_GC_EN] & ~q.sh[0] &     // [R7]
                   (q.sh[7:1] == `GENERAL_CALL_ADDR);

   // Software clears the step flag by writing a one to it.
   assign clearFlag = busReq.wr & (busReq.addr == `OFS_CONTROL) &
                      busReq.wdata[`CTL_STEP_DONE] & q.flag;

   // Next-state logic for registers, bus engine and outputs.
   always_comb begin
      d = q;
      d.sclPrev  = sclS;
      d.sdaPrev  = sdaS;
      d.wake     = 1'b0;
      d.startOut = 1'b0;
      if (arbLost) begin
         d.arb = 1'b1;
      end

      // Register writes from the local port.
      if (busReq.wr) begin
         unique case (busReq.addr)
            `OFS_OWN_ADDR: begin
               d.ownAddr = busReq.wdata;
            end
            `OFS_CONTROL: begin
               d.ackEn    = busReq.wdata[`CTL_ACK_EN];
               d.startReq = busReq.wdata[`CTL_START_REQ];
               d.stopReq  = busReq.wdata[`CTL_STOP_REQ];
               d.ifaceEn  = busReq.wdata[`CTL_IFACE_EN];
               d.irqEn    = busReq.wdata[`CTL_IRQ_EN];
            end
            `OFS_STATUS: begin
               d.presc = busReq.wdata[1:0];
            end
            `OFS_DATA: begin
               if (q.flag) begin
                  d.dataReg = busReq.wdata;                // [R19]
                  d.wcol    = 1'b0;
               end else begin
                  d.wcol = 1'b1;
               end
            end
         endcase
      end

      // Register reads answer in the next cycle.
      if (busReq.rd) begin
         unique case (busReq.addr)
            `OFS_OWN_ADDR: d.rdata = q.ownAddr;
            `OFS_CONTROL:  d.rdata = {q.flag, q.ackEn, q.startReq,
                                      q.stopReq, q.wcol, q.ifaceEn,
                                      1'b0, q.irqEn};
            `OFS_STATUS:   d.rdata = ((q.flag ? q.code : `ST_NO_INFO) &
                                      `ST_CODE_MASK) |         // [R18]
                                     {6'h00, q.presc};
            `OFS_DATA:     d.rdata = q.dataReg;
         endcase
      end

      // Flag clear releases the held step and picks the next phase.
      if (clearFlag) begin
         d.flag = 1'b0;
         if (d.stopReq || q.nextSt == two_wire_pkg::PH_IDLE) begin
            d.st      = two_wire_pkg::PH_IDLE;                 // [R2] [R3]
            if (d.startReq && !d.stopReq) begin
               d.startPend = 1'b1;                             // [R5]
            end
            d.stopReq = 1'b0;                                  // [R20]
            d.sdaDrv  = 1'b0;
         end else if (q.nextSt == two_wire_pkg::PH_TX) begin
            d.st       = two_wire_pkg::PH_TX;
            d.cnt      = 4'h0;
            d.txSh     = q.dataReg;
            d.sdaDrv   = ~q.dataReg[7];
            d.lastByte = ~d.ackEn;                             // [R12] [R19]
         end else begin
            d.st      = two_wire_pkg::PH_RX;
            d.cnt     = 4'h0;
            d.ackNext = d.ackEn;                               // [R1]
         end
      end

      // Bus free tracking and the deferred START request.
      if (startCond) begin
         d.busy = 1'b1;
      end else if (stopCond) begin
         d.busy = 1'b0;
      end
      if (!d.startReq) begin
         d.startPend = 1'b0;
      end else if (q.startPend && !q.busy) begin
         d.startOut  = 1'b1;                                   // [R5]
         d.startPend = 1'b0;
      end

      // Line events; a set here overrides a clear above.
      if (!q.ifaceEn) begin
         d.st     = two_wire_pkg::PH_IDLE;
         d.sdaDrv = 1'b0;
      end else if (q.st != two_wire_pkg::PH_HOLD &&
                   (startCond || stopCond)) begin
         if (q.st == two_wire_pkg::PH_IDLE) begin
            if (startCond) begin
               d.st  = two_wire_pkg::PH_ADDR;                  // [R14]
               d.cnt = 4'h0;
            end
         end else if (q.st == two_wire_pkg::PH_ADDR &&
                      q.cnt <= 4'h1 && startCond) begin
            d.cnt = 4'h0;
         end else if (q.st == two_wire_pkg::PH_RX &&
                      q.cnt <= 4'h1) begin  // First bit high may end.
            d.flag    = 1'b1;                                  // [R3]
            d.code    = `ST_STOP_RESTART;
            d.st      = two_wire_pkg::PH_HOLD;
            d.nextSt  = two_wire_pkg::PH_IDLE;
            d.stretch = 1'b0;
            d.sdaDrv  = 1'b0;
         end else begin
            d.flag    = 1'b1;                                  // [R20]
            d.code    = `ST_BUS_ERROR;
            d.st      = two_wire_pkg::PH_HOLD;
            d.nextSt  = two_wire_pkg::PH_IDLE;
            d.stretch = 1'b0;
            d.sdaDrv  = 1'b0;
         end
      end else begin
         unique case (q.st)
            two_wire_pkg::PH_IDLE, two_wire_pkg::PH_HOLD: begin
               // Idle or held step: no bit is sampled; a held step may keep the clock low.
            end
            two_wire_pkg::PH_ADDR, two_wire_pkg::PH_RX: begin
               if (sclRise) begin
                  d.sh  = {q.sh[6:0], sdaS};
                  d.cnt = q.cnt + 4'h1;
               end else if (sclFall && q.cnt == `BITS_PER_BYTE) begin
                  d.cnt = 4'h0;
                  d.st  = two_wire_pkg::PH_ACK;
                  if (q.st == two_wire_pkg::PH_RX) begin
                     d.addrPhase = 1'b0;
                     d.dataReg   = q.sh;
                     d.sdaDrv    = q.ackNext;                  // [R1] [R2]
                  end else if (ownHit || gcHit) begin
                     d.addrPhase = 1'b1;
                     d.rdMode    = q.sh[0];                    // [R9]
                     d.gc        = gcHit & ~ownHit;
                     d.sdaDrv    = 1'b1;
                  end else begin
                     d.st = two_wire_pkg::PH_IDLE;             // [R14]
                  end
               end
            end
            two_wire_pkg::PH_ACK: begin
               if (sclRise) begin
                  d.cnt = 4'h1;
               end else if (sclFall && q.cnt == 4'h1) begin
                  d.sdaDrv = 1'b0;
                  d.flag   = 1'b1;                             // [R10]
                  d.st     = two_wire_pkg::PH_HOLD;
                  if (q.addrPhase) begin
                     d.stretch = 1'b1;                         // [R16]
                     d.arb     = 1'b0;
                     d.wake    = sleepDeep;                    // [R15]
                     if (!sleepDeep) begin
                        d.dataReg = q.sh;                      // [R17]
                     end
                     if (q.rdMode) begin
                        d.nextSt = two_wire_pkg::PH_TX;        // [R9]
                        d.code   = q.arb ? `ST_ARB_OWN_R       // [R11]
                                         : `ST_OWN_R_ACK;
                     end else begin
                        d.nextSt = two_wire_pkg::PH_RX;
                        if (q.gc) begin
                           d.code = q.arb ? `ST_ARB_GC : `ST_GC_ACK;
                        end else begin
                           d.code = q.arb ? `ST_ARB_OWN_W
                                          : `ST_OWN_W_ACK;
                        end
                     end
                  end else begin
                     d.stretch = q.ackNext;
                     d.nextSt  = q.ackNext ? two_wire_pkg::PH_RX
                                           : two_wire_pkg::PH_IDLE;
                     if (q.gc) begin
                        d.code = q.ackNext ? `ST_GC_DATA_ACK   // [R1]
                                           : `ST_GC_DATA_NACK; // [R2]
                     end else begin
                        d.code = q.ackNext ? `ST_DATA_ACK
                                           : `ST_DATA_NACK;
                     end
                  end
               end
            end
            two_wire_pkg::PH_TX: begin
               if (sclFall) begin
                  if (q.cnt == `LAST_TX_BIT) begin
                     d.sdaDrv = 1'b0;
                     d.st     = two_wire_pkg::PH_MACK;
                  end else begin
                     d.txSh   = {q.txSh[6:0], 1'b0};
                     d.sdaDrv = ~q.txSh[6];
                     d.cnt    = q.cnt + 4'h1;
                  end
               end
            end
            two_wire_pkg::PH_MACK: begin
               if (sclRise) begin
                  d.mAck = ~sdaS;
               end else if (sclFall) begin
                  d.flag  = 1'b1;
                  d.st    = two_wire_pkg::PH_HOLD;
                  if (q.mAck && !q.lastByte) begin
                     d.code    = `ST_TX_ACK;                   // [R19]
                     d.nextSt  = two_wire_pkg::PH_TX;
                     d.stretch = 1'b1;
                  end else begin
                     d.code    = q.mAck ? `ST_TX_LAST_ACK      // [R12]
                                        : `ST_TX_NACK;
                     d.nextSt  = two_wire_pkg::PH_IDLE;        // [R13]
                     d.stretch = 1'b0;
                  end
               end
            end
            default: begin
               d.st     = two_wire_pkg::PH_IDLE;
               d.sdaDrv = 1'b0;
            end
         endcase
      end

      // Clock stretch stands only in a held step that asks for it.
      d.sclHold = (d.st == two_wire_pkg::PH_HOLD) & d.stretch;  // [R16]
   end

   // State register with constant reset values.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q         <= '0;
         q.st      <= two_wire_pkg::PH_IDLE;
         q.nextSt  <= two_wire_pkg::PH_IDLE;
         q.ownAddr <= `RST_OWN_ADDR;
         q.dataReg <= `RST_BYTE;
         q.sclPrev <= 1'b1;
         q.sdaPrev <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Output drive; both lines are open drain and only pulled low.
   assign sclOut     = 1'b0;
   assign sdaOut     = 1'b0;
   assign sclOe      = q.sclHold;
   assign sdaOe      = q.sdaDrv;
   assign rdData     = q.rdata;
   assign wakeUp     = q.wake;
   assign startIssue = q.startOut;
   assign stepDone   = q.flag;
endmodule : two_wire_slave_engine

// *** testbench/two_wire_slave_engine_chk.sv ***
// Assertion checker bound to the two-wire slave engine ports.
`timescale 1ns/100ps
`include "two_wire_consts.svh"
module two_wire_slave_engine_chk (
   input wire logic                    clk,
   input wire logic                    rst_b,
   input wire two_wire_pkg::host_req_t busReq,
   input wire logic [7:0]              rdData,
   input wire logic                    sclIn,
   input wire logic                    sclOut,
   input wire logic                    sclOe,
   input wire logic                    sdaIn,
   input wire logic                    sdaOut,
   input wire logic                    sdaOe,
   input wire logic                    arbLost,
   input wire logic                    sleepDeep,
   input wire logic                    wakeUp,
   input wire logic                    startIssue,
   input wire logic                    stepDone
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   logic ctlWr;
   // A write to the control register, which alone may clear the flag.
   assign ctlWr = busReq.wr && busReq.addr == `OFS_CONTROL;
   hold_needs_flag_a: assert property (sclOe |-> stepDone)
      else $error("clock held without the step flag");
   flag_clear_a: assert property (
      ctlWr && busReq.wdata[`CTL_STEP_DONE] && stepDone
      |=> !stepDone && !sclOe)
      else $error("flag clear write ignored");
   flag_stays_a: assert property (
      stepDone && !ctlWr |=> stepDone)
      else $error("step flag dropped without a clear");
   hold_with_flag_a: assert property (
      $rose(sclOe) |-> $rose(stepDone))
      else $error("clock hold began apart from the flag");
   wake_in_sleep_a: assert property (
      wakeUp |-> $past(sleepDeep) && !$past(wakeUp))
      else $error("wake pulse outside deep sleep");
   start_pulse_a: assert property (
      startIssue |=> !startIssue)
      else $error("start request longer than one cycle");
   start_bus_free_a: assert property (
      startIssue |-> !stepDone && sclIn && sdaIn)
      else $error("start issued while the bus is busy");
   sda_low_clock_a: assert property (
      $changed(sdaOe) |-> !sclIn)
      else $error("data line changed while clock high");
   wake_c: cover property (wakeUp);
   start_c: cover property (startIssue);
   release_c: cover property ($fell(sclOe));
endmodule : two_wire_slave_engine_chk

bind two_wire_slave_engine two_wire_slave_engine_chk chk (
   .clk(clk), .rst_b(rst_b), .busReq(busReq), .rdData(rdData),
   .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .arbLost(arbLost),
   .sleepDeep(sleepDeep), .wakeUp(wakeUp), .startIssue(startIssue),
   .stepDone(stepDone));

// *** testbench/two_wire_master_model.sv ***
// Open-drain bus master model for the two-wire link.
`timescale 1ns/100ps
module two_wire_master_model (
   output logic      sclDrv,
   output logic      sdaDrv,
   input  wire logic scl,
   input  wire logic sda
);
   // Both lines released, so the pull-ups keep the bus idle.
   initial begin
      sclDrv = 1'b1;
      sdaDrv = 1'b1;
   end
   // One 125 ns bit: data set in the low half, sampled in the high half.
   task automatic bitXfer(input logic b, output logic r);
      sdaDrv = b;
      #31.2;
      sclDrv = 1'b1;
      wait (scl === 1'b1); // A slave stretch is waited out.
      #31.3;
      r = sda;
      #31.2;
      sclDrv = 1'b0;
      #31.3;
   endtask : bitXfer
   // Eight bits first to last from the top, then the acknowledge bit.
   task automatic byteXfer(input logic [7:0] tx, input logic ackIn,
                           output logic [7:0] rx, output logic ackOut);
      for (int i = 7; i >= 0; i--) begin
         bitXfer(tx[i], rx[i]);
      end
      bitXfer(ackIn, ackOut);
   endtask : byteXfer
   // Data falls while the clock is high.
   task automatic start();
      sdaDrv = 1'b1;
      #31.2;
      sclDrv = 1'b1;
      #62.5;
      sdaDrv = 1'b0;
      #62.5;
      sclDrv = 1'b0;
      #31.3;
   endtask : start
   // Data rises while the clock is high; the clock then stands still.
   task automatic stop();
      sdaDrv = 1'b0;
      #31.2;
      sclDrv = 1'b1;
      wait (scl === 1'b1);
      #62.5;
      sdaDrv = 1'b1;
      #62.5;
   endtask : stop
endmodule : two_wire_master_model

// *** testbench/tb.sv ***
// Self-checking bench for the two-wire slave engine.
`timescale 1ns/100ps
`include "two_wire_consts.svh"
module tb;
   logic                    clk, rst_b, a, sclOut, sclOe, sdaOut, sdaOe;
   logic                    sclDrv, sdaDrv, sclW, sdaW, arbLost;
   logic                    sleepDeep, wakeUp, startIssue, stepDone;
   two_wire_pkg::host_req_t busReq;
   logic [7:0]              rdData, v, d, rx;
   logic [6:0]              own;
   int                      mismatches, compares, wakes, starts, n;
   // Open-drain wires: low whenever either party pulls.
   assign sclW = sclDrv & ~(sclOe & ~sclOut);
   assign sdaW = sdaDrv & ~(sdaOe & ~sdaOut);
   two_wire_slave_engine dut (.clk(clk), .rst_b(rst_b), .busReq(busReq),
      .rdData(rdData), .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe),
      .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .arbLost(arbLost),
      .sleepDeep(sleepDeep), .wakeUp(wakeUp), .startIssue(startIssue),
      .stepDone(stepDone));
   two_wire_master_model m (.sclDrv(sclDrv), .sdaDrv(sdaDrv), .scl(sclW),
      .sda(sdaW));
   // System clock at 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Counts the one-cycle request pulses of the engine.
   always @(negedge clk) begin
      if (wakeUp === 1'b1) wakes++;
      if (startIssue === 1'b1) starts++;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [1:0] ad, input logic [7:0] dat);
      @(posedge clk);
      busReq <= '{addr: ad, wdata: dat, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] ad, output logic [7:0] dat);
      @(posedge clk);
      busReq <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      busReq.rd <= 1'b0;
      @(negedge clk);
      dat = rdData;
   endtask : rd
   // Waits a bounded time for the flag, then compares the masked status.
   task automatic step(input logic [7:0] e);
      for (int i = 0; i < 400 && stepDone !== 1'b1; i++) @(negedge clk);
      rd(`OFS_STATUS, v);
      check(v & `ST_CODE_MASK, e);
   endtask : step
   // Master sends one byte and releases the line for the answer.
   task automatic send(input logic [7:0] b, input logic e);
      m.byteXfer(b, 1'b1, rx, a);
      check({7'h00, a}, {7'h00, e});
   endtask : send
   task automatic results();
      if (mismatches == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   // Cuts a hung run short well past the expected length.
   initial begin
      #150us;
      mismatches++;
      results();
   end
   initial begin
      busReq = '0;
      rst_b = 1'b0;
      arbLost = 1'b0;
      sleepDeep = 1'b0;
      n = $urandom(32'h82cb0ef8);
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      own = 7'($urandom_range(127, 1));
      wr(`OFS_OWN_ADDR, {own, 1'b1});
      wr(`OFS_CONTROL, 8'h44);
      // Transmit, plain and after lost arbitration, final ACK or NACK.
      for (int k = 0; k < 4; k++) begin
         if (k[1]) begin
            @(posedge clk);
            arbLost <= 1'b1;
            @(posedge clk);
            arbLost <= 1'b0;
         end
         m.start();
         send({own, 1'b1}, 1'b0);
         step(k[1] ? `ST_ARB_OWN_R : `ST_OWN_R_ACK);
         d = 8'($urandom);
         wr(`OFS_DATA, d);
         wr(`OFS_CONTROL, 8'hc4);
         m.byteXfer(8'hff, 1'b0, rx, a);
         check(rx, d);
         step(`ST_TX_ACK);
         d = 8'($urandom);
         wr(`OFS_DATA, d);
         wr(`OFS_CONTROL, 8'h84);
         m.byteXfer(8'hff, k[0], rx, a);
         check(rx, d);
         step(k[0] ? `ST_TX_NACK : `ST_TX_LAST_ACK);
         n = starts;
         wr(`OFS_CONTROL, 8'he4);
         send(8'hff, 1'b1);
         check(rx, 8'hff);
         m.stop();
         for (int i = 0; i < 100 && starts == n; i++) @(negedge clk);
         check(8'(starts - n), 8'h01);
         wr(`OFS_CONTROL, 8'h44);
      end
      // General call data acknowledged, then refused.
      m.start();
      send({`GENERAL_CALL_ADDR, 1'b0}, 1'b0);
      step(`ST_GC_ACK);
      wr(`OFS_CONTROL, 8'hc4);
      d = 8'($urandom);
      send(d, 1'b0);
      step(`ST_GC_DATA_ACK);
      rd(`OFS_DATA, v);
      check(v, d);
      wr(`OFS_CONTROL, 8'h84);
      send(~d, 1'b1);
      step(`ST_GC_DATA_NACK);
      wr(`OFS_CONTROL, 8'hc4);
      send(d, 1'b1);
      m.stop();
      // Refused addresses: call disabled, then ack enable clear.
      for (int j = 0; j < 3; j++) begin
         wr(`OFS_OWN_ADDR, {own, j != 0});
         wr(`OFS_CONTROL, j != 0 ? 8'h04 : 8'h44);
         m.start();
         send(j == 1 ? {own, 1'b0} : 8'h00, 1'b1);
         check({7'h00, stepDone}, 8'h00);
         m.stop();
      end
      // Wake from deep sleep; clock held until the flag is cleared.
      wr(`OFS_CONTROL, 8'h44);
      sleepDeep <= 1'b1;
      n = wakes;
      m.start();
      send({own, 1'b0}, 1'b0);
      step(`ST_OWN_W_ACK);
      check(8'(wakes - n), 8'h01);
      check({7'h00, sclOe}, 8'h01);
      @(posedge clk);
      sleepDeep <= 1'b0;
      wr(`OFS_CONTROL, 8'hc4);
      @(negedge clk);
      check({7'h00, sclOe}, 8'h00);
      m.stop();
      step(`ST_STOP_RESTART);
      check({7'h00, sclOe}, 8'h00);
      wr(`OFS_CONTROL, 8'hc4);
      // STOP in mid byte is a bus error; stop request recovers.
      m.start();
      send({own, 1'b0}, 1'b0);
      step(`ST_OWN_W_ACK);
      wr(`OFS_CONTROL, 8'hc4);
      m.bitXfer(1'b0, a);
      m.bitXfer(1'b1, a);
      m.stop();
      step(`ST_BUS_ERROR);
      wr(`OFS_CONTROL, 8'hd4);
      rd(`OFS_CONTROL, v);
      check(v, 8'h44);
      step(`ST_NO_INFO);
      results();
   end
endmodule : tb
